/* logic/pin_select_pkg.sv */
/*
  constants, field layout and carrier types of the remappable pin selection map.
  assumes a 32-bit apb master with byte strobes on a single 100 MHz clock.
*/
package pin_select_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_N       = 14;
  localparam int unsigned OUT_REG_N   = 10;
  localparam logic [5:0]  IDX_CAN_RX  = 6'h00;
  localparam logic [5:0]  IDX_SYNC    = 6'h01;
  localparam logic [5:0]  IDX_DTC_1   = 6'h02;
  localparam logic [5:0]  IDX_DTC_23  = 6'h03;
  localparam logic [5:0]  IDX_OUT_0   = 6'h04;
  localparam logic [5:0]  IDX_LAST    = 6'h0D;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned SEL_IN_W    = 7;
  localparam int unsigned SEL_OUT_W   = 6;
  localparam int unsigned POS_LO      = 0;
  localparam int unsigned POS_HI      = 8;
  localparam logic [9:0]  OUT_LO_IMPL = 10'h27F;
  localparam logic [9:0]  OUT_HI_IMPL = 10'h1FF;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  CODE_VSS     = 7'h00;
  localparam logic [6:0]  CODE_CMP     = 7'h01;
  localparam logic [6:0]  CODE_PIN_MAX = 7'h79;
  localparam logic [6:0]  IN_SEL_RST   = 7'h00;
  localparam logic [5:0]  OUT_SEL_RST  = 6'h00;
  localparam int unsigned NUM_PIN_IN   = 122;
  localparam int unsigned NUM_FUNC     = 64;

  typedef logic [SEL_IN_W-1:0]  in_sel_t;
  typedef logic [SEL_OUT_W-1:0] out_sel_t;

  typedef struct packed {
    in_sel_t can_rx;
    in_sel_t pwm_sync;
    in_sel_t dtc_first;
    in_sel_t dtc_second;
    in_sel_t dtc_third;
  } in_sel_s;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } apb_req_s;

  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } apb_rsp_s;

endpackage

/* logic/input_route_mux.sv */
/*
  one remapped peripheral input: picks ground, comparator one or a numbered pin.
  assumes pins and comparator are synchronous to pclk.
*/
`timescale 1ns/100ps
module input_route_mux
  import pin_select_pkg::*;
#(
  parameter int unsigned SEL_W   = SEL_IN_W,
  parameter int unsigned PIN_N   = NUM_PIN_IN
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic [PIN_N-1:0] pins,
  input  wire logic             comparator_one_output,
  output logic                  routed_q
);

  logic routed_d;

  // ----------------------------------------------------------------
  // source select
  // ----------------------------------------------------------------
  always_comb begin
    routed_d = 1'b0;
    if (sel == SEL_W'(CODE_VSS)) begin
      routed_d = 1'b0;
    end else if (sel == SEL_W'(CODE_CMP)) begin
      routed_d = comparator_one_output;
    end else if (32'(sel) < PIN_N) begin
      routed_d = pins[sel];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routed_q <= 1'b0;
    end else begin
      routed_q <= routed_d;
    end
  end

endmodule // input_route_mux

/* logic/pin_select_map.sv */
/*
  remappable pin selection map: apb register file, input routing of five
  peripheral inputs and function routing onto seventeen remappable output pins.
  assumes a 32-bit apb master, synchronous pins and peripheral function outputs.
*/
`timescale 1ns/100ps
module pin_select_map
  import pin_select_pkg::*;
#(
  parameter int unsigned PIN_N  = NUM_PIN_IN,
  parameter int unsigned FUNC_N = NUM_FUNC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire apb_req_s               apb_req,
  output apb_rsp_s                    apb_rsp,
  input  wire logic [PIN_N-1:0]       remap_pin_in,
  input  wire logic                   comparator_one_output,
  input  wire logic [FUNC_N-1:0]      periph_func_out,
  output logic                        can_receive_input,
  output logic                        pwm_sync_input,
  output logic                        deadtime_comp_first,
  output logic                        deadtime_comp_second,
  output logic                        deadtime_comp_third,
  output logic [OUT_REG_N-1:0][1:0]   remap_pin_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    in_sel_s                          sel;
    logic [OUT_REG_N-1:0][1:0][5:0]   out_sel;
    logic [DATA_W-1:0]                prdata;
    logic                             pslverr;
    logic [OUT_REG_N-1:0][1:0]        pin_drive;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic [5:0] idx;
  logic       mapped;
  logic       setup;
  logic       wr_access;

  assign idx       = apb_req.paddr[7:2];
  assign mapped    = (idx <= IDX_LAST);
  assign setup     = apb_req.psel && !apb_req.penable;
  assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // ----------------------------------------------------------------
  // register read image
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] read_image(input state_s st, input logic [5:0] ix);
    logic [DATA_W-1:0] v;
    logic [3:0]        k;
    v = '0;
    k = 4'(ix - IDX_OUT_0);
    case (ix)
      IDX_CAN_RX: begin
        v[POS_LO +: SEL_IN_W] = st.sel.can_rx;
      end
      IDX_SYNC: begin
        v[POS_HI +: SEL_IN_W] = st.sel.pwm_sync;
      end
      IDX_DTC_1: begin
        v[POS_HI +: SEL_IN_W] = st.sel.dtc_first;
      end
      IDX_DTC_23: begin
        v[POS_HI +: SEL_IN_W] = st.sel.dtc_third;
        v[POS_LO +: SEL_IN_W] = st.sel.dtc_second;
      end
      default: begin
        if (ix >= IDX_OUT_0 && ix <= IDX_LAST) begin
          v[POS_HI +: SEL_OUT_W] = st.out_sel[k][1];
          v[POS_LO +: SEL_OUT_W] = st.out_sel[k][0];
        end
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] k;
    k   = 4'(idx - IDX_OUT_0);
    s_d = s_q;
    if (setup) begin
      s_d.prdata  = mapped ? read_image(s_q, idx) : '0;
      s_d.pslverr = !mapped;
    end
    if (wr_access && mapped) begin
      case (idx)
        IDX_CAN_RX: begin
          if (apb_req.pstrb[0]) begin
            s_d.sel.can_rx = apb_req.pwdata[POS_LO +: SEL_IN_W];
          end
        end
        IDX_SYNC: begin
          if (apb_req.pstrb[1]) begin
            s_d.sel.pwm_sync = apb_req.pwdata[POS_HI +: SEL_IN_W];
          end
        end
        IDX_DTC_1: begin
          if (apb_req.pstrb[1]) begin
            s_d.sel.dtc_first = apb_req.pwdata[POS_HI +: SEL_IN_W];
          end
        end
        IDX_DTC_23: begin
          if (apb_req.pstrb[1]) begin
            s_d.sel.dtc_third = apb_req.pwdata[POS_HI +: SEL_IN_W];
          end
          if (apb_req.pstrb[0]) begin
            s_d.sel.dtc_second = apb_req.pwdata[POS_LO +: SEL_IN_W];
          end
        end
        default: begin
          // unimplemented slots never load, so they read zero
          if (apb_req.pstrb[1] && OUT_HI_IMPL[k]) begin
            s_d.out_sel[k][1] = apb_req.pwdata[POS_HI +: SEL_OUT_W];
          end
          if (apb_req.pstrb[0] && OUT_LO_IMPL[k]) begin
            s_d.out_sel[k][0] = apb_req.pwdata[POS_LO +: SEL_OUT_W];
          end
        end
      endcase
    end
    // function routing onto output pins, code zero leaves the pin unassigned
    for (int r = 0; r < OUT_REG_N; r++) begin
      for (int h = 0; h < 2; h++) begin
        if (s_q.out_sel[r][h] == OUT_SEL_RST) begin
          s_d.pin_drive[r][h] = 1'b0;
        end else if (32'(s_q.out_sel[r][h]) < FUNC_N) begin
          s_d.pin_drive[r][h] = periph_func_out[s_q.out_sel[r][h]];
        end else begin
          s_d.pin_drive[r][h] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.sel.can_rx     <= IN_SEL_RST;
      s_q.sel.pwm_sync   <= IN_SEL_RST;
      s_q.sel.dtc_first  <= IN_SEL_RST;
      s_q.sel.dtc_second <= IN_SEL_RST;
      s_q.sel.dtc_third  <= IN_SEL_RST;
      s_q.out_sel        <= '0;
      s_q.prdata         <= '0;
      s_q.pslverr        <= 1'b0;
      s_q.pin_drive      <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = s_q.prdata;
  assign apb_rsp.pslverr = s_q.pslverr && apb_req.psel && apb_req.penable;
  assign remap_pin_out   = s_q.pin_drive;

  // ----------------------------------------------------------------
  // input routing
  // ----------------------------------------------------------------
  input_route_mux #(.SEL_W(SEL_IN_W), .PIN_N(PIN_N)) u_can_rx (
    .pclk                  (pclk),
    .presetn               (presetn),
    .sel                   (s_q.sel.can_rx),
    .pins                  (remap_pin_in),
    .comparator_one_output (comparator_one_output),
    .routed_q              (can_receive_input)
  );

  input_route_mux #(.SEL_W(SEL_IN_W), .PIN_N(PIN_N)) u_pwm_sync (
    .pclk                  (pclk),
    .presetn               (presetn),
    .sel                   (s_q.sel.pwm_sync),
    .pins                  (remap_pin_in),
    .comparator_one_output (comparator_one_output),
    .routed_q              (pwm_sync_input)
  );

  input_route_mux #(.SEL_W(SEL_IN_W), .PIN_N(PIN_N)) u_dtc_first (
    .pclk                  (pclk),
    .presetn               (presetn),
    .sel                   (s_q.sel.dtc_first),
    .pins                  (remap_pin_in),
    .comparator_one_output (comparator_one_output),
    .routed_q              (deadtime_comp_first)
  );

  input_route_mux #(.SEL_W(SEL_IN_W), .PIN_N(PIN_N)) u_dtc_second (
    .pclk                  (pclk),
    .presetn               (presetn),
    .sel                   (s_q.sel.dtc_second),
    .pins                  (remap_pin_in),
    .comparator_one_output (comparator_one_output),
    .routed_q              (deadtime_comp_second)
  );

  input_route_mux #(.SEL_W(SEL_IN_W), .PIN_N(PIN_N)) u_dtc_third (
    .pclk                  (pclk),
    .presetn               (presetn),
    .sel                   (s_q.sel.dtc_third),
    .pins                  (remap_pin_in),
    .comparator_one_output (comparator_one_output),
    .routed_q              (deadtime_comp_third)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pin121_route;
    (s_q.sel.dtc_first == CODE_PIN_MAX) ##1 (s_q.sel.dtc_first == CODE_PIN_MAX)
      |-> deadtime_comp_first == $past(remap_pin_in[121]);
  endproperty
  a_pin121_route: assert property (p_pin121_route) else $error("pin 121 not routed");

  property p_cmp_route;
    (s_q.sel.pwm_sync == CODE_CMP) ##1 (s_q.sel.pwm_sync == CODE_CMP)
      |-> pwm_sync_input == $past(comparator_one_output);
  endproperty
  a_cmp_route: assert property (p_cmp_route) else $error("comparator not routed");

  property p_vss_route;
    (s_q.sel.can_rx == CODE_VSS) [*2] |-> !can_receive_input;
  endproperty
  a_vss_route: assert property (p_vss_route) else $error("tied input not low");

  property p_reserved_zero;
    (apb_req.psel && apb_req.penable && !apb_req.pwrite)
      |-> (apb_rsp.prdata[31:15] == '0) && (apb_rsp.prdata[7:6] == 2'b00 || idx < IDX_OUT_0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_can_write;
    (wr_access && idx == IDX_CAN_RX && apb_req.pstrb[0])
      |=> s_q.sel.can_rx == $past(apb_req.pwdata[6:0]);
  endproperty
  a_can_write: assert property (p_can_write) else $error("can selector not written");

  property p_dtc1_layout;
    (setup && idx == IDX_DTC_1) |=> (s_q.prdata[7:0] == 8'h00) && (s_q.prdata[14:8] == $past(s_q.sel.dtc_first));
  endproperty
  a_dtc1_layout: assert property (p_dtc1_layout) else $error("dead-time first layout wrong");

  property p_out_drive;
    (s_q.out_sel[0][1] != OUT_SEL_RST) ##1 $stable(s_q.out_sel[0][1])
      |-> remap_pin_out[0][1] == $past(periph_func_out[s_q.out_sel[0][1]]);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output function not routed");

  property p_pin97_low_empty;
    s_q.out_sel[7][0] == OUT_SEL_RST && !remap_pin_out[7][0];
  endproperty
  a_pin97_low_empty: assert property (p_pin97_low_empty) else $error("pin 97 low byte used");

  property p_pin120_high_empty;
    s_q.out_sel[9][1] == OUT_SEL_RST && !remap_pin_out[9][1];
  endproperty
  a_pin120_high_empty: assert property (p_pin120_high_empty) else $error("pin 120 high field used");

  property p_reset_clear;
    $rose(presetn) |-> (s_q.sel == '0) && (s_q.out_sel == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared by reset");

  // ----------------------------------------------------------------
  // field load, read image, tied input and reset routing
  // ----------------------------------------------------------------
  property p_dtc1_write;
    (wr_access && idx == IDX_DTC_1 && apb_req.pstrb[1])
      |=> s_q.sel.dtc_first == $past(apb_req.pwdata[14:8]);
  endproperty
  a_dtc1_write: assert property (p_dtc1_write) else $error("dead-time first selector not written");

  property p_out_write;
    (wr_access && idx == IDX_OUT_0 && apb_req.pstrb[1] && apb_req.pstrb[0])
      |=> s_q.out_sel[0] == {$past(apb_req.pwdata[13:8]), $past(apb_req.pwdata[5:0])};
  endproperty
  a_out_write: assert property (p_out_write) else $error("output fields not written");

  property p_pin97_write;
    (wr_access && idx == IDX_OUT_0 + 6'h07 && apb_req.pstrb[1])
      |=> s_q.out_sel[7][1] == $past(apb_req.pwdata[13:8]);
  endproperty
  a_pin97_write: assert property (p_pin97_write) else $error("pin 97 field not written");

  property p_pin97_read;
    (setup && idx == IDX_OUT_0 + 6'h07)
      |=> (s_q.prdata[7:0] == 8'h00) && (s_q.prdata[13:8] == $past(s_q.out_sel[7][1]));
  endproperty
  a_pin97_read: assert property (p_pin97_read) else $error("pin 97 read image wrong");

  property p_pin120_write;
    (wr_access && idx == IDX_LAST && apb_req.pstrb[0])
      |=> s_q.out_sel[9][0] == $past(apb_req.pwdata[5:0]);
  endproperty
  a_pin120_write: assert property (p_pin120_write) else $error("pin 120 field not written");

  property p_pin120_read;
    (setup && idx == IDX_LAST)
      |=> (s_q.prdata[31:6] == '0) && (s_q.prdata[5:0] == $past(s_q.out_sel[9][0]));
  endproperty
  a_pin120_read: assert property (p_pin120_read) else $error("pin 120 read image wrong");

  property p_can_read;
    (setup && idx == IDX_CAN_RX)
      |=> s_q.prdata == {25'h0000000, $past(s_q.sel.can_rx)};
  endproperty
  a_can_read: assert property (p_can_read) else $error("can selector read image wrong");

  property p_unmapped_read;
    (setup && !mapped)
      |=> (s_q.prdata == '0) && s_q.pslverr;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped slot not refused");

  property p_vss_first;
    (s_q.sel.dtc_first == CODE_VSS) [*2] |-> !deadtime_comp_first;
  endproperty
  a_vss_first: assert property (p_vss_first) else $error("tied dead-time input not low");

  property p_reset_route;
    $rose(presetn) |-> !can_receive_input && !pwm_sync_input && !deadtime_comp_first
      && !deadtime_comp_second && !deadtime_comp_third && (remap_pin_out == '0);
  endproperty
  a_reset_route: assert property (p_reset_route) else $error("routed outputs not cleared by reset");

  c_can_write: cover property (wr_access && idx == IDX_CAN_RX);
  c_out_read: cover property (setup && !apb_req.pwrite && idx == IDX_OUT_0);
  c_unmapped: cover property (apb_rsp.pslverr);
  c_pin121: cover property (s_q.sel.dtc_first == CODE_PIN_MAX);
  c_cmp_route: cover property (s_q.sel.pwm_sync == CODE_CMP);

endmodule // pin_select_map

/* verif/pad_periph_model.sv */
/*
  partner model: remappable pads, comparator one and peripheral function outputs.
  assumes the bench sets the wanted levels; they reach the map one edge later.
*/
`timescale 1ns/100ps
module pad_periph_model
  import pin_select_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic [NUM_PIN_IN-1:0] pin_set,
  input  wire logic                  cmp_set,
  input  wire logic [NUM_FUNC-1:0]   func_set,
  output logic      [NUM_PIN_IN-1:0] remap_pin_in,
  output logic                       comparator_one_output,
  output logic      [NUM_FUNC-1:0]   periph_func_out
);
  // ----------------------------------------------------------------
  // pad and peripheral levels, changed only after a clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    remap_pin_in          <= pin_set;
    comparator_one_output <= cmp_set;
    periph_func_out       <= func_set;
  end
endmodule // pad_periph_model

/* verif/remappable_pin_select_map_test.sv */
/*
  self-checking bench of the pin selection map: apb register access, input and
  output routing, reset. assumes the partner model in pad_periph_model.sv.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t mismatch got %h exp %h", $time, got, exp); end end
module remappable_pin_select_map_test;
  import pin_select_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                        pclk;
  logic                        presetn;
  apb_req_s                    req;
  apb_rsp_s                    rsp;
  logic [NUM_PIN_IN-1:0]       pin_set;
  logic                        cmp_set;
  logic [NUM_FUNC-1:0]         func_set;
  logic [NUM_PIN_IN-1:0]       pins;
  logic                        cmp;
  logic [NUM_FUNC-1:0]         funcs;
  wire  [4:0]                  routed;
  logic [OUT_REG_N-1:0][1:0]   pin_out;
  int                          fail_count;
  int                          n_tests;
  localparam logic [31:0] MASK [REG_N] = '{32'h0000007F, 32'h00007F00, 32'h00007F00, 32'h00007F7F,
    32'h00003F3F, 32'h00003F3F, 32'h00003F3F, 32'h00003F3F, 32'h00003F3F, 32'h00003F3F, 32'h00003F3F,
    32'h00003F00, 32'h00003F00, 32'h0000003F};

  pad_periph_model pads (.pclk(pclk), .pin_set(pin_set), .cmp_set(cmp_set), .func_set(func_set),
    .remap_pin_in(pins), .comparator_one_output(cmp), .periph_func_out(funcs));

  pin_select_map dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .remap_pin_in(pins), .comparator_one_output(cmp), .periph_func_out(funcs),
    .can_receive_input(routed[4]), .pwm_sync_input(routed[3]), .deadtime_comp_first(routed[2]),
    .deadtime_comp_second(routed[1]), .deadtime_comp_third(routed[0]), .remap_pin_out(pin_out));

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  function automatic logic [7:0] ad(int i);
    return 8'(i * 4);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, wd, st};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    `CHK(rsp.pready, 1'b1)
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, 4'hF, rd, err);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h00000000, 4'h0, rd, err);
    `CHK(rd, exp)
    `CHK(err, exp_err)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    for (int i = 0; i < REG_N; i++)
      rdchk(ad(i), 32'h00000000, 1'b0);
    `CHK(routed, 5'h00)
    `CHK(pin_out, 20'h00000)
  endtask

  task automatic t_field_masks();
    for (int i = 0; i < REG_N; i++) begin
      wr(ad(i), 32'hFFFFFFFF);
      rdchk(ad(i), MASK[i], 1'b0);
    end
    wr(8'h38, 32'hFFFFFFFF);
    rdchk(8'h38, 32'h00000000, 1'b1);
    for (int i = 0; i < REG_N; i++)
      wr(ad(i), 32'h00000000);
  endtask

  task automatic t_input_route();
    logic [6:0] codes [4] = '{7'h00, 7'h01, 7'h05, 7'h79};
    logic       exp;
    for (int p = 0; p < 2; p++) begin
      pin_set <= (p == 0) ? '1 : '0;
      cmp_set <= (p == 1);
      for (int k = 0; k < 4; k++) begin
        for (int i = 0; i < 4; i++)
          wr(ad(i), {17'h00000, codes[k], 1'b0, codes[k]});
        exp = (codes[k] == 7'h00) ? 1'b0 : (codes[k] == 7'h01) ? (p == 1) : (p == 0);
        repeat (4) @(posedge pclk);
        `CHK(routed, {5{exp}})
      end
    end
  endtask

  task automatic t_output_route();
    for (int i = 4; i < REG_N; i++)
      wr(ad(i), 32'h00000707);
    func_set <= 64'h0000000000000080;
    repeat (4) @(posedge pclk);
    `CHK(pin_out, {2'b01, 2'b10, 2'b10, {7{2'b11}}})
    func_set <= ~64'h0000000000000080;
    repeat (4) @(posedge pclk);
    `CHK(pin_out, 20'h00000)
    for (int i = 4; i < REG_N; i++)
      wr(ad(i), 32'h00000000);
    repeat (4) @(posedge pclk);
    `CHK(pin_out, 20'h00000)
  endtask

  task automatic t_mid_reset();
    wr(ad(0), 32'h00000005);
    wr(ad(13), 32'h0000003F);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(pin_out, 20'h00000)
    presetn <= 1'b1;
    rdchk(ad(0), 32'h00000000, 1'b0);
    rdchk(ad(13), 32'h00000000, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    pin_set = '0;
    cmp_set = 1'b0;
    func_set = '0;
    fail_count = 0;
    n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_field_masks();
    t_input_route();
    t_output_route();
    t_mid_reset();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    test_done();
  end
endmodule // remappable_pin_select_map_test
